// *** design/mb_frame_regs.svh ***
// constants for the modbus rtu slave frame handler
`ifndef MB_FRAME_REGS_SVH
`define MB_FRAME_REGS_SVH
`define MB_UNICAST_ADDR 8'h01
`define MB_BCAST_ADDR 8'h00
`define MB_FC_READ 8'h03
`define MB_FC_WRITE1 8'h06
`define MB_FC_WRITEN 8'h10
`define MB_EXC_FLAG 8'h80
`define MB_EXC_FUNC 8'h01
`define MB_EXC_ADDR 8'h02
`define MB_EXC_VALUE 8'h03
`define MB_CRC_INIT 16'hffff
`define MB_CRC_POLY 16'ha001
`define MB_BAUD 115200
`define MB_CLK_HZ 200000000
`define MB_T35_BITS 39
`define MB_GAP_CYCLES ((`MB_CLK_HZ / `MB_BAUD) * `MB_T35_BITS)
`define MB_MAX_FRAME 16
`endif

// *** design/mb_frame_pkg.sv ***
// types for the modbus rtu slave frame handler
package mb_frame_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_CHECK = 3'b011,
    ST_ACCESS = 3'b010,
    ST_WAIT = 3'b110,
    ST_SEND = 3'b111,
    ST_CRCLO = 3'b101,
    ST_CRCHI = 3'b100
  } mb_state_t;
endpackage

// *** design/mb_frame_buf.sv ***
// small frame byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mb_frame_buf #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule
`default_nettype wire

// *** design/mb_frame_handler.sv ***
// modbus rtu slave request parser and reply former
// Functional notes
// - reply to unicast only when address byte equals fixed address 1
// - address 0 is broadcast: act on it, never reply
// - second byte of every frame is the function code
// - code 0x03 reads one or two 16-bit registers
// - code 0x06 writes exactly one 16-bit register
// - code 0x10 supported only for writing two registers
// - data travels big-endian, most significant register and byte first
// - floats are IEEE-754 single, same byte order as integers
// - malformed request gets function plus 0x80 and one exception code
// - exception 0x01 for unsupported function code
// - exception 0x02 for count mismatch or unknown address/function pair
// - exception 0x03 for count outside 1-2 or bad byte count
// - crc mismatch: discard frame silently
// - crc-16, low byte sent before high byte
// - frame with serial framing error is dropped silently
// - requests arriving while busy overflow and go unanswered
// - inactive until modbus selected; ascii command set is default
// - link runs 115200 baud, 8 data bits, no parity
`timescale 1ns/1ps
`default_nettype none
`include "mb_frame_regs.svh"
module mb_frame_handler #(
  parameter int GAP_CYCLES = `MB_GAP_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic modbus_sel_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_frame_err_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  output logic reg_req_out,
  output logic reg_write_out,
  output logic [15:0] reg_addr_out,
  output logic [1:0] reg_count_out,
  output logic [31:0] reg_wdata_out,
  input wire logic reg_ack_in,
  input wire logic reg_ok_in,
  input wire logic reg_count_ok_in,
  input wire logic [31:0] reg_rdata_in,
  output logic overflow_out
);
  import mb_frame_pkg::*;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      x = x[0] ? ((x >> 1) ^ `MB_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
  localparam int GW = $clog2(GAP_CYCLES + 1);
  localparam logic [GW-1:0] GAP_LAST = GW'(GAP_CYCLES - 1);
  mb_state_t st_q, st_d;
  logic [4:0] len_q, len_d, need;
  logic [15:0] crc_q, crc_d, tcrc_q, tcrc_d, cnt;
  logic [GW-1:0] gap_q, gap_d;
  logic ferr_q, ferr_d, bcast_q, bcast_d;
  logic reg_req_q, reg_req_d, ovf_q, ovf_d;
  logic [7:0] h_q [7];
  logic [7:0] h_d [7];
  logic [31:0] wd_q, wd_d;
  logic [7:0] rsp_q [9];
  logic [7:0] rsp_d [9];
  logic [3:0] rlen_q, rlen_d, ri_q, ri_d;
  logic [7:0] tx_q, tx_d, buf_rd, exc_code;
  logic exc_set, rx_go;
  // the byte store keeps the first 16 bytes of a frame; the reply address is read back
  mb_frame_buf #(.DEPTH(`MB_MAX_FRAME), .AW(4)) u_buf (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(rx_go && len_q < 5'(`MB_MAX_FRAME)),
    .wr_addr_in(len_q[3:0]),
    .wr_data_in(rx_data_in),
    .rd_addr_in(4'h0),
    .rd_data_out(buf_rd)
  );
  // frames only accepted while modbus is the selected protocol
  assign rx_go = rx_valid_in && modbus_sel_in;
  assign cnt = {h_q[4], h_q[5]};
  assign need = (h_q[1] == `MB_FC_WRITEN) ? 5'd13 : 5'd8;
  always_comb
  begin
    exc_set = 1'b0;
    exc_code = 8'h00;
    case (h_q[1])
      `MB_FC_READ, `MB_FC_WRITEN:
      begin
        if (cnt < 16'd1 || cnt > 16'd2)
        begin
          exc_set = 1'b1;
          exc_code = `MB_EXC_VALUE;
        end
        else if (h_q[1] == `MB_FC_WRITEN &&
                 {8'h00, h_q[6]} != {cnt[14:0], 1'b0})
        begin
          exc_set = 1'b1;
          exc_code = `MB_EXC_VALUE;
        end
        else if (h_q[1] == `MB_FC_WRITEN && cnt != 16'd2)
        begin
          exc_set = 1'b1;
          exc_code = `MB_EXC_ADDR;
        end
      end
      `MB_FC_WRITE1: ;
      default:
      begin
        exc_set = 1'b1;
        exc_code = `MB_EXC_FUNC;
      end
    endcase
  end
  always_comb
  begin
    st_d = st_q;
    len_d = len_q;
    crc_d = crc_q;
    gap_d = gap_q;
    ferr_d = ferr_q;
    h_d = h_q;
    wd_d = wd_q;
    rsp_d = rsp_q;
    rlen_d = rlen_q;
    ri_d = ri_q;
    tcrc_d = tcrc_q;
    bcast_d = bcast_q;
    reg_req_d = reg_req_q;
    ovf_d = 1'b0;
    tx_d = tx_q;
    case (st_q)
      ST_IDLE, ST_RECV:
      begin
        if (rx_go)
        begin
          st_d = ST_RECV;
          gap_d = '0;
          len_d = (len_q == 5'd31) ? len_q : len_q + 5'd1;
          crc_d = crc_byte(crc_q, rx_data_in);
          ferr_d = ferr_q | rx_frame_err_in;
          if (len_q < 5'd7)
          begin
            h_d[len_q[2:0]] = rx_data_in;
          end
          // crc bytes of a single write must not reach the write data
          if (len_q == 5'd4 || len_q == 5'd5 ||
              (h_q[1] == `MB_FC_WRITEN && len_q >= 5'd7 && len_q <= 5'd10))
          begin
            wd_d = {wd_q[23:0], rx_data_in};
          end
        end
        else if (st_q == ST_RECV)
        begin
          st_d = (gap_q == GAP_LAST) ? ST_CHECK : ST_RECV;
          gap_d = gap_q + GW'(1);
        end
      end
      ST_CHECK:
      begin
        st_d = ST_IDLE;
        len_d = '0;
        crc_d = `MB_CRC_INIT;
        ferr_d = 1'b0;
        gap_d = '0;
        bcast_d = (h_q[0] == `MB_BCAST_ADDR);
        rsp_d[0] = buf_rd;
        // residue of zero means the crc matched
        if (!ferr_q && crc_q == 16'h0000 && len_q >= 5'd4 &&
            (h_q[0] == `MB_UNICAST_ADDR || h_q[0] == `MB_BCAST_ADDR))
        begin
          if (exc_set || len_q != need)
          begin
            rsp_d[1] = h_q[1] | `MB_EXC_FLAG;
            rsp_d[2] = exc_set ? exc_code : `MB_EXC_VALUE;
            rlen_d = 4'd3;
            st_d = bcast_d ? ST_IDLE : ST_SEND;
          end
          else
          begin
            reg_req_d = 1'b1;
            st_d = ST_ACCESS;
          end
        end
      end
      ST_ACCESS:
      begin
        if (reg_ack_in)
        begin
          reg_req_d = 1'b0;
          rsp_d[1] = h_q[1];
          if (!reg_ok_in || !reg_count_ok_in)
          begin
            rsp_d[1] = h_q[1] | `MB_EXC_FLAG;
            rsp_d[2] = `MB_EXC_ADDR;
            rlen_d = 4'd3;
          end
          else if (h_q[1] == `MB_FC_READ)
          begin
            rsp_d[2] = {cnt[6:0], 1'b0};
            if (cnt == 16'd2)
            begin
              rsp_d[3] = reg_rdata_in[31:24];
              rsp_d[4] = reg_rdata_in[23:16];
              rsp_d[5] = reg_rdata_in[15:8];
              rsp_d[6] = reg_rdata_in[7:0];
              rlen_d = 4'd7;
            end
            else
            begin
              rsp_d[3] = reg_rdata_in[15:8];
              rsp_d[4] = reg_rdata_in[7:0];
              rlen_d = 4'd5;
            end
          end
          else
          begin
            for (int i = 2; i < 6; i++)
            begin
              rsp_d[i] = h_q[i];
            end
            rlen_d = 4'd6;
          end
          st_d = bcast_q ? ST_IDLE : ST_SEND;
        end
      end
      default:
      begin
        st_d = tx_valid_out ? st_q : ST_IDLE;
      end
    endcase
    // send states move below; bytes arriving now overflow and are lost
    if ((st_q == ST_CHECK || st_q == ST_ACCESS) && rx_go)
    begin
      ovf_d = 1'b1;
    end
    if (st_q == ST_SEND || st_q == ST_CRCLO || st_q == ST_CRCHI)
    begin
      ovf_d = rx_go;
      if (tx_ready_in)
      begin
        case (st_q)
          ST_SEND:
          begin
            tcrc_d = crc_byte(tcrc_q, tx_q);
            if (ri_q + 4'd1 == rlen_q)
            begin
              st_d = ST_CRCLO;
              tx_d = tcrc_d[7:0];
            end
            else
            begin
              ri_d = ri_q + 4'd1;
              tx_d = rsp_q[ri_q + 4'd1];
            end
          end
          ST_CRCLO:
          begin
            st_d = ST_CRCHI;
            tx_d = tcrc_q[15:8];
          end
          default:
          begin
            st_d = ST_IDLE;
            ri_d = '0;
            tcrc_d = `MB_CRC_INIT;
            tx_d = 8'h00;
          end
        endcase
      end
    end
    if (st_d == ST_SEND && st_q != ST_SEND)
    begin
      tx_d = rsp_d[0];
      ri_d = '0;
      tcrc_d = `MB_CRC_INIT;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_IDLE;
      len_q <= '0;
      crc_q <= `MB_CRC_INIT;
      gap_q <= '0;
      ferr_q <= 1'b0;
      h_q <= '{default: 8'h00};
      wd_q <= '0;
      rsp_q <= '{default: 8'h00};
      rlen_q <= '0;
      ri_q <= '0;
      tcrc_q <= `MB_CRC_INIT;
      bcast_q <= 1'b0;
      reg_req_q <= 1'b0;
      ovf_q <= 1'b0;
      tx_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      len_q <= len_d;
      crc_q <= crc_d;
      gap_q <= gap_d;
      ferr_q <= ferr_d;
      h_q <= h_d;
      wd_q <= wd_d;
      rsp_q <= rsp_d;
      rlen_q <= rlen_d;
      ri_q <= ri_d;
      tcrc_q <= tcrc_d;
      bcast_q <= bcast_d;
      reg_req_q <= reg_req_d;
      ovf_q <= ovf_d;
      tx_q <= tx_d;
    end
  end
  assign tx_valid_out = (st_q == ST_SEND) || (st_q == ST_CRCLO) ||
                        (st_q == ST_CRCHI);
  assign tx_data_out = tx_q;
  assign reg_req_out = reg_req_q;
  assign reg_write_out = (h_q[1] != `MB_FC_READ);
  assign reg_addr_out = {h_q[2], h_q[3]};
  // single write carries its value in the count field position
  assign reg_count_out = (h_q[1] == `MB_FC_WRITE1) ? 2'd1 : cnt[1:0];
  assign reg_wdata_out = (h_q[1] == `MB_FC_WRITE1) ?
                         {16'h0000, wd_q[15:0]} : wd_q;
  assign overflow_out = ovf_q;
endmodule
`default_nettype wire

// *** testbench/mb_frame_handler_assertions.sv ***
// port-level assertions for the modbus rtu frame handler
`timescale 1ns/1ps
`default_nettype none
module mb_frame_handler_assertions #(
  parameter int GAP_CYCLES = 20
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic modbus_sel_in,
  input wire logic rx_valid_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire logic reg_req_out,
  input wire logic [15:0] reg_addr_out,
  input wire logic [1:0] reg_count_out,
  input wire logic reg_ack_in,
  input wire logic overflow_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  sequence acked;
    reg_req_out && reg_ack_in;
  endsequence
  sequence held;
    reg_req_out && !reg_ack_in;
  endsequence
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("reply byte moved");
  req_hold_a: assert property (held |=> reg_req_out &&
    $stable(reg_addr_out) && $stable(reg_count_out))
    else $error("register request moved");
  req_drop_a: assert property (acked |=> !reg_req_out)
    else $error("request stayed after ack");
  count_range_a: assert property (reg_req_out |->
    reg_count_out inside {2'd1, 2'd2}) else $error("count not 1 or 2");
  quiet_access_a: assert property (reg_req_out |-> !tx_valid_out)
    else $error("reply before register answer");
  ovf_cause_a: assert property (overflow_out |-> $past(rx_valid_in))
    else $error("overflow without a byte");
  ovf_flag_a: assert property (rx_valid_in && modbus_sel_in &&
    tx_valid_out |=> overflow_out) else $error("lost byte not flagged");
  one_access_a: assert property (acked |=> !reg_req_out [*8])
    else $error("second access without new frame");
  cover property (acked);
endmodule
bind mb_frame_handler mb_frame_handler_assertions #(
  .GAP_CYCLES(GAP_CYCLES)
) chk_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .modbus_sel_in(modbus_sel_in), .rx_valid_in(rx_valid_in),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
  .tx_ready_in(tx_ready_in), .reg_req_out(reg_req_out),
  .reg_addr_out(reg_addr_out), .reg_count_out(reg_count_out),
  .reg_ack_in(reg_ack_in), .overflow_out(overflow_out));
`default_nettype wire

// *** testbench/mb_reg_model.sv ***
// register side model: answers requests after an address-chosen delay
`timescale 1ns/1ps
`default_nettype none
module mb_reg_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [15:0] addr_in,
  output logic ack_out,
  output logic ok_out,
  output logic count_ok_out,
  output logic [31:0] rdata_out
);
  logic [2:0] cnt_q;
  // low address bits set the latency so prompt and slow answers both occur
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      ack_out <= 1'b0;
      cnt_q <= 3'h0;
    end
    else
    begin
      ack_out <= 1'b0;
      if (req_in && !ack_out)
      begin
        ack_out <= (cnt_q == addr_in[2:0]);
        cnt_q <= (cnt_q == addr_in[2:0]) ? 3'h0 : cnt_q + 3'h1;
      end
    end
  end
  assign ok_out = (addr_in != 16'hffff);
  assign count_ok_out = 1'b1;
  assign rdata_out = {addr_in, ~addr_in};
endmodule
`default_nettype wire

// *** testbench/test_mb_frame_handler.sv ***
// self-checking bench for the modbus rtu frame handler
`timescale 1ns/1ps
`default_nettype none
module test_mb_frame_handler;
  typedef logic [7:0] bytes_t[$];
  localparam int GAP = 20;
  logic clk_sys_in = 0, rst_in = 1, modbus_sel_in = 1;
  logic rx_valid_in = 0, rx_frame_err_in = 0, tx_ready_in = 0;
  logic [7:0] rx_data_in = 8'h00;
  logic tx_valid_out, reg_req_out, reg_write_out, overflow_out;
  logic reg_ack_in, reg_ok_in, reg_count_ok_in;
  logic [7:0] tx_data_out;
  logic [15:0] reg_addr_out;
  logic [1:0] reg_count_out;
  logic [31:0] reg_wdata_out, reg_rdata_in, exp_w;
  logic [15:0] exp_a = 16'h0000;
  logic [7:0] exp_fc = 8'h00;
  logic [7:0] exp_q[$];
  int num_errors = 0, checks_done = 0, ack_n = 0, ovf_n = 0, cyc = 0, n0;
  integer seed = 32'h8259;
  mb_frame_handler #(.GAP_CYCLES(GAP)) uut (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .modbus_sel_in(modbus_sel_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .rx_frame_err_in(rx_frame_err_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
    .reg_req_out(reg_req_out), .reg_write_out(reg_write_out),
    .reg_addr_out(reg_addr_out), .reg_count_out(reg_count_out),
    .reg_wdata_out(reg_wdata_out), .reg_ack_in(reg_ack_in),
    .reg_ok_in(reg_ok_in), .reg_count_ok_in(reg_count_ok_in),
    .reg_rdata_in(reg_rdata_in), .overflow_out(overflow_out));
  mb_reg_model regs (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .req_in(reg_req_out), .addr_in(reg_addr_out), .ack_out(reg_ack_in),
    .ok_out(reg_ok_in), .count_ok_out(reg_count_ok_in),
    .rdata_out(reg_rdata_in));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) tx_ready_in <= 1'($random(seed));
  function automatic logic [15:0] crc(bytes_t b);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i])
    begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(logic [7:0] d, logic fe);
    @(negedge clk_sys_in);
    rx_valid_in = 1;
    rx_data_in = d;
    rx_frame_err_in = fe;
    @(negedge clk_sys_in);
    rx_valid_in = 0;
    rx_frame_err_in = 0;
  endtask
  // crc goes low byte first; a bad frame has one crc bit flipped
  task automatic run(string n, bytes_t f, bytes_t e, bit bad = 0,
    bit fe = 0, bit ov = 0);
    logic [15:0] c;
    int o;
    c = crc(f);
    exp_fc = f[1];
    exp_a = {f[2], f[3]};
    f.push_back(c[7:0] ^ {7'h00, bad});
    f.push_back(c[15:8]);
    if (e.size() > 0)
    begin
      c = crc(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    foreach (e[i]) exp_q.push_back(e[i]);
    foreach (f[i]) pulse(f[i], fe && i == 1);
    if (ov)
    begin
      o = ovf_n;
      for (int k = 0; k < 400 && tx_valid_out !== 1'b1; k++)
        @(negedge clk_sys_in);
      pulse(8'h55, 1'b0);
      @(negedge clk_sys_in);
      chk("overflow", o + 1, ovf_n);
    end
    for (int k = 0; k < 600 && exp_q.size() > 0; k++) @(negedge clk_sys_in);
    repeat (GAP + 20) @(negedge clk_sys_in);
    chk("pending", 0, exp_q.size());
    $display("end of test %s", n);
  endtask
  always @(posedge clk_sys_in)
  begin
    if (!rst_in && tx_valid_out === 1'b1 && tx_ready_in)
      chk("tx", exp_q.size() > 0 ? exp_q.pop_front() : 32'h100,
        tx_data_out);
    if (!rst_in && reg_ack_in === 1'b1)
    begin
      ack_n++;
      chk("rw", exp_fc != 8'h03, reg_write_out);
      chk("addr", exp_a, reg_addr_out);
    end
    if (reg_ack_in === 1'b1 && reg_write_out === 1'b1)
      chk("wdata", exp_w, reg_count_out == 2'd2 ? reg_wdata_out :
        {16'h0000, reg_wdata_out[15:0]});
    if (overflow_out === 1'b1)
      ovf_n++;
    cyc++;
    if (cyc == 10000)
    begin
      num_errors++;
      results();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_sys_in);
    rst_in = 0;
    run("read2", '{8'h01, 8'h03, 8'h30, 8'h20, 8'h00, 8'h02},
      '{8'h01, 8'h03, 8'h04, 8'h30, 8'h20, 8'hcf, 8'hdf});
    run("read1", '{8'h01, 8'h03, 8'h10, 8'hb7, 8'h00, 8'h01},
      '{8'h01, 8'h03, 8'h02, 8'hef, 8'h48});
    exp_w = 32'h0000_0001;
    run("write1", '{8'h01, 8'h06, 8'h80, 8'h30, 8'h00, 8'h01},
      '{8'h01, 8'h06, 8'h80, 8'h30, 8'h00, 8'h01});
    exp_w = 32'h40a0_0000;
    run("writen", '{8'h01, 8'h10, 8'h30, 8'h10, 8'h00, 8'h02,
      8'h04, 8'h40, 8'ha0, 8'h00, 8'h00},
      '{8'h01, 8'h10, 8'h30, 8'h10, 8'h00, 8'h02});
    run("badfn", '{8'h01, 8'h04, 8'h30, 8'h20, 8'h00, 8'h01},
      '{8'h01, 8'h84, 8'h01});
    run("count3", '{8'h01, 8'h03, 8'h30, 8'h20, 8'h00, 8'h03},
      '{8'h01, 8'h83, 8'h03});
    run("count0", '{8'h01, 8'h03, 8'h30, 8'h20, 8'h00, 8'h00},
      '{8'h01, 8'h83, 8'h03});
    run("bytecnt", '{8'h01, 8'h10, 8'h30, 8'h10, 8'h00, 8'h02, 8'h03,
      8'h40, 8'ha0, 8'h00}, '{8'h01, 8'h90, 8'h03});
    run("n1", '{8'h01, 8'h10, 8'h30, 8'h10, 8'h00, 8'h01, 8'h02,
      8'h00, 8'h05}, '{8'h01, 8'h90, 8'h02});
    run("nak", '{8'h01, 8'h03, 8'hff, 8'hff, 8'h00, 8'h01},
      '{8'h01, 8'h83, 8'h02});
    run("badcrc", '{8'h01, 8'h03, 8'h30, 8'h20, 8'h00, 8'h02}, '{}, 1);
    run("ferr", '{8'h01, 8'h03, 8'h30, 8'h20, 8'h00, 8'h02}, '{}, 0, 1);
    run("addr5", '{8'h05, 8'h03, 8'h30, 8'h20, 8'h00, 8'h02}, '{});
    exp_w = 32'h0000_0001;
    n0 = ack_n;
    run("bcast", '{8'h00, 8'h06, 8'h80, 8'h30, 8'h00, 8'h01}, '{});
    chk("bcast acks", n0 + 1, ack_n);
    modbus_sel_in = 0;
    run("unsel", '{8'h01, 8'h03, 8'h30, 8'h20, 8'h00, 8'h02}, '{});
    modbus_sel_in = 1;
    run("ovf", '{8'h01, 8'h03, 8'h30, 8'h20, 8'h00, 8'h02},
      '{8'h01, 8'h03, 8'h04, 8'h30, 8'h20, 8'hcf, 8'hdf}, 0, 0, 1);
    results();
  end
endmodule
`default_nettype wire
